// *** hdl/rlc_pkg.sv ***
// shared constants and types for the link core command bits
package rlc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [31:0] LINK_CORE_CONTROL_ADDR = 32'h0400_0000;
    localparam logic [31:0] LINK_CORE_CONTROL_RESET = 32'h0000_0000;
    localparam int NUM_CMD = 5;
    // command slots and their bit positions in link_core_control
    localparam int CMD_CORE_RST = 0;
    localparam int CMD_TG_RST = 1;
    localparam int CMD_REG_RST = 2;
    localparam int CMD_RF_ABORT = 3;
    localparam int CMD_ADV_ABORT = 4;
    localparam int CMD_POS [0:4] = '{31, 30, 29, 26, 25};

    // ----------------------------------------
    // bus constants
    // ----------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int RST_PULSE_NS = 32;
    localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {RLC_TEST_NONE, RLC_TEST_INF_TX, RLC_TEST_INF_RX} rlc_test_mode_t;
    typedef enum logic [1:0] {RLC_AB_IDLE, RLC_AB_TX_BYTE, RLC_AB_TX_CRC, RLC_AB_RX_PKT} rlc_abort_state_t;

    // status from the packet controller
    typedef struct packed {
        rlc_test_mode_t mode;
        logic byteEnd;
        logic crcDone;
        logic aaSeen;
        logic pktEnd;
    } rlc_pc_status_t;

    // orders to the packet controller
    typedef struct packed {
        logic stopPkt;
        logic finishCrc;
        logic radioOff;
    } rlc_pc_ctrl_t;

    // reset and abort requests to the rest of the core
    typedef struct packed {
        logic coreRst;
        logic tgRst;
        logic regRst;
        logic advAbort;
    } rlc_core_ctrl_t;

endpackage : rlc_pkg

// *** hdl/rlc_cmd_bit.sv ***
// one self-clearing command bit with optional fixed-length action
`timescale 1ns/10ps
`default_nettype none
module rlc_cmd_bit #(
    parameter bit USE_TIMER = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic setCmd,
    input wire logic clrCmd,
    input wire logic doneIn,
    output logic cmdOut,
    output logic doneOut
);
    logic cmdFf, nxt_cmdFf;
    logic [rlc_pkg::CNT_W-1:0] cntFf, nxt_cntFf;
    logic finish;

    // ----------------------------------------
    // next state: set beats a clear in the same cycle
    // ----------------------------------------
    always_comb begin
        if (USE_TIMER) begin
            finish = cmdFf && (cntFf == rlc_pkg::CNT_W'(rlc_pkg::RST_PULSE_CYCLES - 1));
        end else begin
            finish = cmdFf && doneIn;
        end
        nxt_cmdFf = cmdFf;
        nxt_cntFf = cmdFf ? cntFf + 1'b1 : cntFf;
        if (finish || clrCmd) begin
            nxt_cmdFf = 1'b0;
            nxt_cntFf = '0;
        end
        // a fresh write restarts the action once the old one is over
        if (setCmd) begin
            nxt_cmdFf = 1'b1;
            if (!cmdFf || finish || clrCmd) begin
                nxt_cntFf = '0;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdFf <= 1'b0;
            cntFf <= '0;
        end else begin
            cmdFf <= nxt_cmdFf;
            cntFf <= nxt_cntFf;
        end
    end

    assign cmdOut = cmdFf;
    assign doneOut = finish;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_cell_set;
        setCmd |=> cmdFf;
    endproperty
    a_cell_set: assert property (p_cell_set) else $error("command bit not set by write of one");

    property p_cell_clear;
        doneOut && !setCmd |=> !cmdFf;
    endproperty
    a_cell_clear: assert property (p_cell_clear) else $error("command bit not cleared after action");

    property p_cell_hold;
        $rose(cmdFf) && USE_TIMER |-> (cmdFf || $past(clrCmd) || $past(clrCmd, 2) || $past(clrCmd, 3))[*4];
    endproperty
    a_cell_hold: assert property (p_cell_hold) else $error("reset action shorter than four cycles");

endmodule : rlc_cmd_bit
`default_nettype wire

// *** hdl/rlc_ahb_front.sv ***
// ahb-lite slave front end for the single control word
`timescale 1ns/10ps
`default_nettype none
module rlc_ahb_front (
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [31:0] regRdVal,
    output logic wrEn
);
    logic wrFf, nxt_wrFf;
    logic [31:0] rdFf, nxt_rdFf;
    logic take, hit;

    // ----------------------------------------
    // address phase decode
    // ----------------------------------------
    // unmapped or narrow accesses read zero and write nothing
    always_comb begin
        take = hsel && (htrans == rlc_pkg::HTRANS_NONSEQ) && hready;
        hit = take && (haddr == rlc_pkg::LINK_CORE_CONTROL_ADDR) && (hsize == rlc_pkg::HSIZE_WORD);
        nxt_wrFf = hit && hwrite;
        nxt_rdFf = rdFf;
        if (take) begin
            nxt_rdFf = (hit && !hwrite) ? regRdVal : 32'h0000_0000;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wrFf <= 1'b0;
            rdFf <= 32'h0000_0000;
        end else begin
            wrFf <= nxt_wrFf;
            rdFf <= nxt_rdFf;
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = rlc_pkg::HRESP_OKAY;
    assign hrdata = rdFf;
    assign wrEn = wrFf;

endmodule : rlc_ahb_front
`default_nettype wire

// *** hdl/rlc_link_core_ctrl.sv ***
// command bits of the link core control register with rf test abort sequencing
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - writing one to bit 31 resets the core except registers and timing generator
// - writing one to bit 30 resets only the timing generator, then clears
// - writing one to bit 29 returns register block to reset, then clears
// - writing one to bit 26 aborts current rf test, then clears; zero ignored
// - continuous transmit abort finishes current byte and checksum before stopping
// - continuous receive abort waits for packet end if access address seen, else radio off
// - writing one to bit 25 aborts advertising event, then clears; zero ignored
module rlc_link_core_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire rlc_pkg::rlc_pc_status_t pcStatus,
    input wire logic advAbortDone,
    output rlc_pkg::rlc_pc_ctrl_t pcCtrl,
    output rlc_pkg::rlc_core_ctrl_t coreCtrl
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic wrEn;
    logic [31:0] regRdVal;
    logic [rlc_pkg::NUM_CMD-1:0] cmdVec;
    logic [rlc_pkg::NUM_CMD-1:0] setVec;
    logic [rlc_pkg::NUM_CMD-1:0] doneVec;
    logic [rlc_pkg::NUM_CMD-1:0] finVec;
    logic regClr;
    logic abortSrst;
    logic accept;
    rlc_pkg::rlc_abort_state_t stateFf, nxt_stateFf;
    logic stopFf, nxt_stopFf;
    logic crcFf, nxt_crcFf;
    logic offFf, nxt_offFf;
    logic rfDoneFf, nxt_rfDoneFf;

    // ----------------------------------------
    // register read value
    // ----------------------------------------
    // places each command bit at its word position, all else zero
    function automatic logic [31:0] pack_cmds(input logic [rlc_pkg::NUM_CMD-1:0] c);
        logic [31:0] w;
        w = rlc_pkg::LINK_CORE_CONTROL_RESET;
        for (int i = 0; i < rlc_pkg::NUM_CMD; i++) begin
            w[rlc_pkg::CMD_POS[i]] = c[i];
        end
        return w;
    endfunction : pack_cmds

    // reserved and unused bits stay zero
    assign regRdVal = pack_cmds(cmdVec);

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    rlc_ahb_front u_front (
        .clk(clk),
        .srst(srst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regRdVal(regRdVal),
        .wrEn(wrEn)
    );

    // ----------------------------------------
    // command bits
    // ----------------------------------------
    // only ones written start an action; zeros are ignored
    always_comb begin
        for (int i = 0; i < rlc_pkg::NUM_CMD; i++) begin
            setVec[i] = wrEn && hwdata[rlc_pkg::CMD_POS[i]];
        end
    end

    // completion sources of the two abort bits
    always_comb begin
        doneVec = '0;
        doneVec[rlc_pkg::CMD_RF_ABORT] = rfDoneFf;
        doneVec[rlc_pkg::CMD_ADV_ABORT] = advAbortDone;
    end

    // register block reset ends by clearing every command bit
    assign regClr = finVec[rlc_pkg::CMD_REG_RST];

    // the three reset bits run a fixed pulse, the aborts wait for completion
    generate
        for (genvar g = 0; g < rlc_pkg::NUM_CMD; g++) begin : g_cmd
            rlc_cmd_bit #(
                .USE_TIMER(g <= rlc_pkg::CMD_REG_RST)
            ) u_bit (
                .clk(clk),
                .srst(srst),
                .setCmd(setVec[g]),
                .clrCmd(regClr),
                .doneIn(doneVec[g]),
                .cmdOut(cmdVec[g]),
                .doneOut(finVec[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // reset and abort requests
    // ----------------------------------------
    // levels straight from the command flip-flops
    always_comb begin
        coreCtrl.coreRst = cmdVec[rlc_pkg::CMD_CORE_RST];
        coreCtrl.tgRst = cmdVec[rlc_pkg::CMD_TG_RST];
        coreCtrl.regRst = cmdVec[rlc_pkg::CMD_REG_RST];
        coreCtrl.advAbort = cmdVec[rlc_pkg::CMD_ADV_ABORT];
    end

    // ----------------------------------------
    // rf test abort sequencer
    // ----------------------------------------
    // the sequencer is core logic, so the core soft reset clears it too
    assign abortSrst = srst || cmdVec[rlc_pkg::CMD_CORE_RST];

    // done flop still high blocks a second take of the same request
    assign accept = cmdVec[rlc_pkg::CMD_RF_ABORT] && (stateFf == rlc_pkg::RLC_AB_IDLE) && !rfDoneFf;

    // next state and the orders to the packet controller
    always_comb begin
        nxt_stateFf = stateFf;
        nxt_stopFf = 1'b0;
        nxt_crcFf = crcFf;
        nxt_offFf = 1'b0;
        nxt_rfDoneFf = 1'b0;
        unique case (stateFf)
            rlc_pkg::RLC_AB_IDLE: begin
                if (accept) begin
                    if (pcStatus.mode == rlc_pkg::RLC_TEST_INF_TX) begin
                        nxt_stateFf = rlc_pkg::RLC_AB_TX_BYTE;
                    end else if (pcStatus.mode == rlc_pkg::RLC_TEST_INF_RX && pcStatus.aaSeen) begin
                        nxt_stateFf = rlc_pkg::RLC_AB_RX_PKT;
                    end else if (pcStatus.mode == rlc_pkg::RLC_TEST_INF_RX) begin
                        nxt_offFf = 1'b1;
                        nxt_stopFf = 1'b1;
                        nxt_rfDoneFf = 1'b1;
                    end else begin
                        // no test running: nothing to stop
                        nxt_rfDoneFf = 1'b1;
                    end
                end
            end
            rlc_pkg::RLC_AB_TX_BYTE: begin
                // byte in flight is never cut short
                if (pcStatus.byteEnd) begin
                    nxt_crcFf = 1'b1;
                    nxt_stateFf = rlc_pkg::RLC_AB_TX_CRC;
                end
            end
            rlc_pkg::RLC_AB_TX_CRC: begin
                if (pcStatus.crcDone) begin
                    nxt_crcFf = 1'b0;
                    nxt_stopFf = 1'b1;
                    nxt_rfDoneFf = 1'b1;
                    nxt_stateFf = rlc_pkg::RLC_AB_IDLE;
                end
            end
            rlc_pkg::RLC_AB_RX_PKT: begin
                if (pcStatus.pktEnd) begin
                    nxt_stopFf = 1'b1;
                    nxt_offFf = 1'b1;
                    nxt_rfDoneFf = 1'b1;
                    nxt_stateFf = rlc_pkg::RLC_AB_IDLE;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (abortSrst) begin
            stateFf <= rlc_pkg::RLC_AB_IDLE;
            stopFf <= 1'b0;
            crcFf <= 1'b0;
            offFf <= 1'b0;
            rfDoneFf <= 1'b0;
        end else begin
            stateFf <= nxt_stateFf;
            stopFf <= nxt_stopFf;
            crcFf <= nxt_crcFf;
            offFf <= nxt_offFf;
            rfDoneFf <= nxt_rfDoneFf;
        end
    end

    // packet controller orders
    always_comb begin
        pcCtrl.stopPkt = stopFf;
        pcCtrl.finishCrc = crcFf;
        pcCtrl.radioOff = offFf;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_core_rst_len;
        $rose(coreCtrl.coreRst) && !cmdVec[rlc_pkg::CMD_REG_RST] |-> coreCtrl.coreRst[*4];
    endproperty
    a_core_rst_len: assert property (p_core_rst_len) else $error("core reset too short");

    property p_core_holds_seq;
        cmdVec[rlc_pkg::CMD_CORE_RST] |=> stateFf == rlc_pkg::RLC_AB_IDLE && !stopFf && !crcFf && !rfDoneFf;
    endproperty
    a_core_holds_seq: assert property (p_core_holds_seq) else $error("abort sequencer ran in core reset");

    // a write with no command bit set must start nothing
    property p_zero_write_idle;
        wrEn && (hwdata & pack_cmds('1)) == 32'h0000_0000 && cmdVec == '0 |=> cmdVec == '0;
    endproperty
    a_zero_write_idle: assert property (p_zero_write_idle) else $error("write of zero started an action");

    property p_tg_rst_clear;
        $rose(coreCtrl.tgRst) ##1 !setVec[1] [*4] |-> !coreCtrl.tgRst;
    endproperty
    a_tg_rst_clear: assert property (p_tg_rst_clear) else $error("timing reset bit not cleared");

    property p_reg_rst_clear;
        regClr && !setVec[0] |=> !cmdVec[0];
    endproperty
    a_reg_rst_clear: assert property (p_reg_rst_clear) else $error("register reset left bits set");

    property p_rf_abort_clear;
        rfDoneFf && !setVec[3] && !regClr |=> !regRdVal[26] && !cmdVec[3];
    endproperty
    a_rf_abort_clear: assert property (p_rf_abort_clear) else $error("rf abort bit not cleared");

    property p_tx_byte_first;
        stateFf == rlc_pkg::RLC_AB_TX_BYTE && !pcStatus.byteEnd && !cmdVec[0] |=> !stopFf && !rfDoneFf;
    endproperty
    a_tx_byte_first: assert property (p_tx_byte_first) else $error("tx abort stopped mid byte");

    property p_tx_crc;
        stateFf == rlc_pkg::RLC_AB_TX_BYTE && pcStatus.byteEnd && !cmdVec[0] |=> crcFf && !stopFf;
    endproperty
    a_tx_crc: assert property (p_tx_crc) else $error("checksum not finished before stop");

    property p_tx_stop;
        stateFf == rlc_pkg::RLC_AB_TX_CRC && pcStatus.crcDone && !cmdVec[0] |=> stopFf && !crcFf && !offFf;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("tx abort did not stop after checksum");

    property p_rx_no_aa;
        accept && pcStatus.mode == rlc_pkg::RLC_TEST_INF_RX && !pcStatus.aaSeen && !cmdVec[0]
            |=> offFf && stopFf && rfDoneFf;
    endproperty
    a_rx_no_aa: assert property (p_rx_no_aa) else $error("rx abort did not switch radio off");

    property p_rx_aa_wait;
        accept && pcStatus.mode == rlc_pkg::RLC_TEST_INF_RX && pcStatus.aaSeen && !cmdVec[0]
            |=> !rfDoneFf && !offFf;
    endproperty
    a_rx_aa_wait: assert property (p_rx_aa_wait) else $error("rx abort cut packet short");

    property p_rx_pkt_end;
        stateFf == rlc_pkg::RLC_AB_RX_PKT && pcStatus.pktEnd && !cmdVec[0] |=> stopFf && offFf && rfDoneFf;
    endproperty
    a_rx_pkt_end: assert property (p_rx_pkt_end) else $error("rx abort did not stop at packet end");

    property p_adv_clear;
        advAbortDone && cmdVec[4] && !setVec[4] && !regClr |=> !coreCtrl.advAbort;
    endproperty
    a_adv_clear: assert property (p_adv_clear) else $error("advertising abort bit not cleared");

    property p_reserved_zero;
        hrdata[28:27] == 2'h0 && hrdata[24:0] == 25'h0 && regRdVal[28:27] == 2'h0 && regRdVal[24:0] == 25'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_reset_zero;
        @(posedge clk) $fell(srst) |-> cmdVec == '0 && hrdata == 32'h0000_0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("command bits nonzero after reset");

    c_core_rst: cover property ($fell(coreCtrl.coreRst));
    c_tx_abort: cover property (stateFf == rlc_pkg::RLC_AB_TX_CRC ##1 rfDoneFf);
    c_rx_abort: cover property (stateFf == rlc_pkg::RLC_AB_RX_PKT ##1 offFf);
    c_adv_abort: cover property ($fell(coreCtrl.advAbort));

endmodule : rlc_link_core_ctrl
`default_nettype wire

// *** dv/radio_link_core_command_bits_tb_top.sv ***
// self-checking bench for the link core command bits
`timescale 1ns/10ps
`default_nettype none
module radio_link_core_command_bits_tb_top;
    // ----------------------------------------
    // signals and design instance
    // ----------------------------------------
    localparam logic [31:0] ADDR = rlc_pkg::LINK_CORE_CONTROL_ADDR;
    localparam int PULSE = rlc_pkg::RST_PULSE_CYCLES;
    typedef struct {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] expRd;
        logic [3:0] expCore;
        int expHi;
    } rlc_row_t;
    logic clk, srst, hsel, hwrite, hreadyout, hresp, advAbortDone;
    logic [31:0] haddr, hwdata, hrdata, rdVal;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire hready;
    rlc_pkg::rlc_pc_status_t pcStat;
    rlc_pkg::rlc_pc_ctrl_t pcCtl;
    rlc_pkg::rlc_core_ctrl_t coreCtl, curCore;
    int errors, checksDone, hiCnt, stopCnt, offCnt, crcCnt;
    // ordinary cases: address, write value, readback during the action, reset pattern, pulse length
    rlc_row_t rows [0:5] = '{
        '{ADDR, 32'h8000_0000, 32'h8000_0000, 4'h8, PULSE},
        '{ADDR, 32'h4000_0000, 32'h4000_0000, 4'h4, PULSE},
        '{ADDR, 32'h2000_0000, 32'h2000_0000, 4'h2, PULSE},
        '{ADDR, 32'h0000_0000, 32'h0000_0000, 4'h0, 0},
        '{ADDR, 32'h19FF_FFFF, 32'h0000_0000, 4'h0, 0},
        '{ADDR + 32'h4, 32'h8000_0000, 32'h0000_0000, 4'h0, 0}
    };

    // the single slave's ready is the bus ready
    assign hready = hreadyout;

    rlc_link_core_ctrl dut (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pcStatus(pcStat), .advAbortDone(advAbortDone), .pcCtrl(pcCtl), .coreCtrl(coreCtl)
    );

    // ----------------------------------------
    // clock, monitors and helpers
    // ----------------------------------------
    // 125 MHz core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // counters sampled mid-cycle, where registered outputs have settled
    always @(negedge clk) begin
        if (coreCtl.coreRst | coreCtl.tgRst | coreCtl.regRst) begin
            hiCnt++;
            check(32'(coreCtl), 32'(curCore));
        end
        stopCnt += int'(pcCtl.stopPkt);
        offCnt += int'(pcCtl.radioOff);
        crcCnt += int'(pcCtl.finishCrc);
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        complete_run();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one single word transfer; waits on ready rather than assuming wait states
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= rlc_pkg::HTRANS_NONSEQ;
        haddr <= addr;
        hwrite <= wr;
        hsize <= rlc_pkg::HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'(rlc_pkg::HRESP_OKAY));
    endtask : ahb

    task automatic clks(input int n);
        repeat (n) @(posedge clk);
    endtask : clks

    // one-cycle status pulse; mask bit 3 byte end, 2 checksum done, 0 packet end
    task automatic pulse(input logic [5:0] m);
        pcStat <= rlc_pkg::rlc_pc_status_t'(pcStat | m);
        @(posedge clk);
        pcStat <= rlc_pkg::rlc_pc_status_t'(pcStat & ~m);
    endtask : pulse

    // start an rf test abort in the given test mode
    task automatic rf_abort(input rlc_pkg::rlc_test_mode_t md, input logic aa);
        pcStat.mode <= md;
        pcStat.aaSeen <= aa;
        stopCnt = 0;
        offCnt = 0;
        crcCnt = 0;
        ahb(1'b1, ADDR, 32'h0400_0000, rdVal);
        clks(4);
    endtask : rf_abort

    task automatic complete_run;
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = rlc_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        pcStat = '0;
        advAbortDone = 1'b0;
        curCore = '0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check(32'(coreCtl), 32'h0);
        check(32'(pcCtl), 32'h0);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, rlc_pkg::LINK_CORE_CONTROL_RESET);
        // table: set, read while active, count the pulse, confirm self-clear
        foreach (rows[i]) begin
            curCore = rows[i].expCore;
            hiCnt = 0;
            ahb(1'b1, rows[i].addr, rows[i].wdata, rdVal);
            ahb(1'b0, rows[i].addr, 32'h0, rdVal);
            check(rdVal, rows[i].expRd);
            clks(8);
            check(32'(hiCnt), 32'(rows[i].expHi));
            ahb(1'b0, ADDR, 32'h0, rdVal);
            check(rdVal, 32'h0);
        end
        // advertising abort stays until the event controller confirms
        ahb(1'b1, ADDR, 32'h0200_0000, rdVal);
        clks(6);
        check(32'(coreCtl), 32'h1);
        advAbortDone <= 1'b1;
        @(posedge clk);
        advAbortDone <= 1'b0;
        clks(2);
        check(32'(coreCtl), 32'h0);
        // register block reset wipes a pending advertising abort too
        curCore = 4'h3;
        ahb(1'b1, ADDR, 32'h0200_0000, rdVal);
        ahb(1'b1, ADDR, 32'h2000_0000, rdVal);
        clks(8);
        check(32'(coreCtl), 32'h0);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, 32'h0);
        // rf abort with no test running: clears without touching the radio
        rf_abort(rlc_pkg::RLC_TEST_NONE, 1'b0);
        check(32'(stopCnt + offCnt), 32'h0);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, 32'h0);
        // receive without access address: stop and radio off at once
        rf_abort(rlc_pkg::RLC_TEST_INF_RX, 1'b0);
        check(32'(stopCnt), 32'h1);
        check(32'(offCnt), 32'h1);
        // receive with access address seen: waits for the packet end
        rf_abort(rlc_pkg::RLC_TEST_INF_RX, 1'b1);
        check(32'(stopCnt), 32'h0);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, 32'h0400_0000);
        pulse(6'h01);
        clks(4);
        check(32'(stopCnt), 32'h1);
        check(32'(offCnt), 32'h1);
        // transmit: finish the byte, then the checksum, then stop
        rf_abort(rlc_pkg::RLC_TEST_INF_TX, 1'b0);
        check(32'(crcCnt + stopCnt), 32'h0);
        pulse(6'h08);
        clks(4);
        check(32'(pcCtl.finishCrc), 32'h1);
        check(32'(stopCnt), 32'h0);
        pulse(6'h04);
        clks(4);
        check(32'(pcCtl.finishCrc), 32'h0);
        check(32'(stopCnt), 32'h1);
        check(32'(offCnt), 32'h0);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, 32'h0);
        // system reset in the middle of a timing generator reset
        pcStat.mode <= rlc_pkg::RLC_TEST_NONE;
        curCore = 4'h4;
        ahb(1'b1, ADDR, 32'h4000_0000, rdVal);
        srst <= 1'b1;
        clks(2);
        check(32'(coreCtl), 32'h0);
        srst <= 1'b0;
        @(posedge clk);
        ahb(1'b0, ADDR, 32'h0, rdVal);
        check(rdVal, 32'h0);
        complete_run();
    end
endmodule : radio_link_core_command_bits_tb_top
`default_nettype wire
